/* File: logic/tcc_defines.vh */
// Constants for the 16-bit timer/event counter with two capture/compare registers.
// Assumes an Avalon-MM master with waitrequest on a 32-bit data bus.
//
// Overview of operation
// - Counter start is not aligned to count clock; first match may slip one tick.
// - One-shot pulse works only in free-running or trigger clear-and-start mode.
// - Clear-on-first-compare mode is left out of os_mode, so no one-shot pulse there.
// - Capture source bit set with both trigger edges valid: no capture to first reg.
// - Capture source bit set: second input edge raises interrupt but captures nothing.
// - Rewriting a compare register at its match is not guaranteed behaviour.
// - Changing second compare without preparation may retake it, toggling output each time.
// - Event counting starts only after two valid edges on the event input.
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// ------------------------------------------------------------
// Register word indexes
// ------------------------------------------------------------
`define TCC_ADDR_CTRL    4'h0
`define TCC_ADDR_CR0     4'h1
`define TCC_ADDR_CR1     4'h2
`define TCC_ADDR_COUNT   4'h3
`define TCC_ADDR_STATUS  4'h4
`define TCC_IDX_W        4

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define TCC_MODE_LSB     0
`define TCC_MODE_MSB     1
`define TCC_CLKSEL_BIT   2
`define TCC_EDGE_LSB     3
`define TCC_EDGE_MSB     4
`define TCC_CSRC_BIT     5
`define TCC_CR0CAP_BIT   6
`define TCC_CR1CAP_BIT   7
`define TCC_OSPT_BIT     8
`define TCC_OSEN_BIT     9
`define TCC_CTRL_W       10

// Operating modes
`define TCC_MODE_STOP    2'h0
`define TCC_MODE_FREE    2'h1
`define TCC_MODE_TRIG    2'h2
`define TCC_MODE_CLRCMP  2'h3

// Edge selections
`define TCC_EDGE_FALL    2'h0
`define TCC_EDGE_RISE    2'h1
`define TCC_EDGE_BOTH    2'h3

`define TCC_ZERO16       16'h0000
`define TCC_ONES16       16'hffff
`define TCC_ONE16        16'h0001
`define TCC_PRESCALE     4'h7
`define TCC_EVT_START    2'h2

`endif

/* File: logic/tcc_timer.v */
// 16-bit timer/event counter with two capture/compare registers and a timer output.
// Assumes trigger and capture inputs are already synchronous to clk_i.
`timescale 1ns/1ps
`include "tcc_defines.vh"
module tcc_timer #(
    parameter PRESCALE = `TCC_PRESCALE
) (
    input  wire        clk_i,            // 50 MHz clock
    input  wire        reset_i,          // Async reset, active high
    input  wire [3:0]  avs_address_i,    // Word address
    input  wire        avs_read_i,       // Read request
    input  wire        avs_write_i,      // Write request
    input  wire [31:0] avs_writedata_i,  // Write data
    input  wire [3:0]  avs_byteenable_i, // Byte enables
    output reg  [31:0] avs_readdata_o,   // Read data
    output reg         avs_waitrequest_o,// Wait request
    input  wire        trig_cap_i,       // trigger_capture_input
    input  wire        cap2_i,           // second_capture_input
    output reg         timer_out_o,      // timer_output_pin
    output reg         match_irq_o       // match_capture_interrupt pulse
);

// ------------------------------------------------------------
// State
// ------------------------------------------------------------
reg [`TCC_CTRL_W-1:0] ctrl_q;
reg [15:0]  cr0_q;       // first_capture_compare_reg
reg [15:0]  cr1_q;       // second_capture_compare_reg
reg [15:0]  cnt_q;       // main_up_counter
reg [3:0]   pre_q;
reg [1:0]   evt_q;       // Valid edges seen in event mode
reg         trig_d1_q;
reg         cap2_d1_q;
reg         ovf_q;
reg         os_active_q;

// ------------------------------------------------------------
// Control fields and edge decode
// ------------------------------------------------------------
wire [1:0] mode    = ctrl_q[`TCC_MODE_MSB:`TCC_MODE_LSB];
wire [1:0] edge_s  = ctrl_q[`TCC_EDGE_MSB:`TCC_EDGE_LSB];
wire       csrc    = ctrl_q[`TCC_CSRC_BIT];
wire       ext_clk = ctrl_q[`TCC_CLKSEL_BIT];

function edge_ok;
    input [1:0] sel;
    input       now;
    input       prev;
    begin
        case (sel)
            `TCC_EDGE_FALL: edge_ok = prev & ~now;
            `TCC_EDGE_RISE: edge_ok = ~prev & now;
            `TCC_EDGE_BOTH: edge_ok = prev ^ now;
            default:        edge_ok = 1'b0;
        endcase
    end
endfunction

// ------------------------------------------------------------
// Tick, match and capture decode
// ------------------------------------------------------------
wire trig_edge = edge_ok(edge_s, trig_cap_i, trig_d1_q);
wire cap2_edge = edge_ok(edge_s, cap2_i, cap2_d1_q);
wire running   = (mode != `TCC_MODE_STOP);
wire bus_wr    = avs_write_i & ~avs_waitrequest_o;

// Prescaler runs freely, so a start lands anywhere in a tick period
wire int_tick  = (pre_q == PRESCALE[3:0]);
wire evt_ready = (evt_q == `TCC_EVT_START);
wire tick      = running & (ext_clk ? (trig_edge & evt_ready) : int_tick);
wire trig_clr  = (mode == `TCC_MODE_TRIG) & ~ext_clk & trig_edge;
wire m0        = tick & (cnt_q == cr0_q) & ~ctrl_q[`TCC_CR0CAP_BIT];
wire m1        = tick & (cnt_q == cr1_q) & ~ctrl_q[`TCC_CR1CAP_BIT];
wire ovf       = tick & (cnt_q == `TCC_ONES16);

// Capture to first register: suppressed when source bit set (both-edge or second input)
wire cap0      = ctrl_q[`TCC_CR0CAP_BIT] & ~csrc & cap2_edge;
wire cap1      = ctrl_q[`TCC_CR1CAP_BIT] & trig_edge & ~ext_clk;
wire cap2_irq  = ctrl_q[`TCC_CR0CAP_BIT] & csrc & cap2_edge;

// One-shot only in free-running or trigger clear-and-start modes
wire os_mode   = (mode == `TCC_MODE_FREE) | (mode == `TCC_MODE_TRIG);
wire os_start  = ctrl_q[`TCC_OSEN_BIT] & os_mode & ~os_active_q &
                 (ctrl_q[`TCC_OSPT_BIT] | trig_clr);

// ------------------------------------------------------------
// Bus slave: one wait cycle per access
// ------------------------------------------------------------
always @(posedge clk_i or posedge reset_i)
begin
    if (reset_i)
    begin
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o    <= 32'h0000_0000;
    end
    else
    begin
        avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
        if (avs_read_i & avs_waitrequest_o)
        begin
            case (avs_address_i)
                `TCC_ADDR_CTRL:   avs_readdata_o <= {22'h00_0000, ctrl_q};
                `TCC_ADDR_CR0:    avs_readdata_o <= {16'h0000, cr0_q};
                `TCC_ADDR_CR1:    avs_readdata_o <= {16'h0000, cr1_q};
                `TCC_ADDR_COUNT:  avs_readdata_o <= {16'h0000, cnt_q};
                `TCC_ADDR_STATUS: avs_readdata_o <= {28'h000_0000, evt_q, os_active_q,
                                                     ovf_q};
                default:          avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end
end

// ------------------------------------------------------------
// Control and compare registers
// ------------------------------------------------------------
always @(posedge clk_i or posedge reset_i)
begin
    if (reset_i)
    begin
        ctrl_q <= {`TCC_CTRL_W{1'b0}};
        cr0_q  <= `TCC_ZERO16;
        cr1_q  <= `TCC_ZERO16;
    end
    else
    begin
        if (bus_wr && avs_address_i == `TCC_ADDR_CTRL && avs_byteenable_i[0])
            ctrl_q[7:0] <= avs_writedata_i[7:0];
        if (bus_wr && avs_address_i == `TCC_ADDR_CTRL && avs_byteenable_i[1])
            ctrl_q[`TCC_CTRL_W-1:8] <= avs_writedata_i[`TCC_CTRL_W-1:8];
        else if (os_start)
            ctrl_q[`TCC_OSPT_BIT] <= 1'b0;
        // Compare writes take effect at once; a write colliding with its match
        // is not protected, so software must rewrite inside the match service
        if (cap0)
            cr0_q <= cnt_q;
        else if (bus_wr && avs_address_i == `TCC_ADDR_CR0)
            cr0_q <= avs_writedata_i[15:0];
        if (cap1)
            cr1_q <= cnt_q;
        else if (bus_wr && avs_address_i == `TCC_ADDR_CR1)
            cr1_q <= avs_writedata_i[15:0];
    end
end

// ------------------------------------------------------------
// Prescaler and input edge history
// ------------------------------------------------------------
always @(posedge clk_i or posedge reset_i)
begin
    if (reset_i)
    begin
        pre_q     <= 4'h0;
        trig_d1_q <= 1'b0;
        cap2_d1_q <= 1'b0;
    end
    else
    begin
        // Never cleared by a start, which is what makes the first tick uncertain
        pre_q     <= int_tick ? 4'h0 : pre_q + 4'h1;
        trig_d1_q <= trig_cap_i;
        cap2_d1_q <= cap2_i;
    end
end

// ------------------------------------------------------------
// Event arming, counter and overflow flag
// ------------------------------------------------------------
always @(posedge clk_i or posedge reset_i)
begin
    if (reset_i)
    begin
        cnt_q <= `TCC_ZERO16;
        evt_q <= 2'h0;
        ovf_q <= 1'b0;
    end
    else
    begin
        if (!running || !ext_clk)
            evt_q <= 2'h0;
        else if (trig_edge && !evt_ready)
            evt_q <= evt_q + 2'h1;
        if (!running)
            cnt_q <= `TCC_ZERO16;
        else if (trig_clr || os_start)
            cnt_q <= `TCC_ZERO16;
        else if (m0 && mode == `TCC_MODE_CLRCMP)
            cnt_q <= `TCC_ZERO16;
        else if (tick)
            cnt_q <= cnt_q + `TCC_ONE16;
        // Overflow flag holds; software clears by writing status, and an
        // overflow in the same cycle as the clear wins so none is lost
        if (ovf)
            ovf_q <= 1'b1;
        else if (bus_wr && avs_address_i == `TCC_ADDR_STATUS)
            ovf_q <= 1'b0;
    end
end

// ------------------------------------------------------------
// One-shot state, timer output and interrupt
// ------------------------------------------------------------
always @(posedge clk_i or posedge reset_i)
begin
    if (reset_i)
    begin
        os_active_q <= 1'b0;
        timer_out_o <= 1'b0;
        match_irq_o <= 1'b0;
    end
    else
    begin
        // One-shot: high from second-compare match to first-compare match
        if (os_start)
            os_active_q <= 1'b1;
        else if (os_active_q && (m0 || !os_mode))
            os_active_q <= 1'b0;
        // Mode gate stops a pulse left over from another mode rising here
        if (!running)
            timer_out_o <= 1'b0;
        else if (ctrl_q[`TCC_OSEN_BIT])
            timer_out_o <= os_active_q & os_mode & (m1 | (timer_out_o & ~m0));
        else if (m0 | m1)
            timer_out_o <= ~timer_out_o;
        match_irq_o <= m0 | cap0 | cap2_irq;
    end
end

endmodule

/* File: test/tcc_event_src.sv */
// Far-side model driving the trigger and second capture inputs.
// Assumes the caller passes a pulse width of at least one clock.
`timescale 1ns/1ps
module tcc_event_src (
    input  wire clk_i,  // Clock
    output reg  trig_o, // Trigger, capture and event input
    output reg  cap2_o  // Second capture input
);
    initial
    begin
        trig_o = 1'b0;
        cap2_o = 1'b0;
    end
    // Wide high and low phases so every edge is seen once
    task pulse(input bit sel, input int w);
        @(posedge clk_i);
        if (sel) cap2_o <= 1'b1; else trig_o <= 1'b1;
        repeat (w) @(posedge clk_i);
        if (sel) cap2_o <= 1'b0; else trig_o <= 1'b0;
        repeat (w) @(posedge clk_i);
    endtask
endmodule

/* File: test/tcc_timer_monitor.sv */
// Checker of the timer's bus handshake, capture interrupt and output.
// Assumes ctrl is always written with every byte lane enabled.
`timescale 1ns/1ps
module tcc_timer_monitor #(
    parameter PRESCALE = 7
) (
    input wire        clk_i,             // Clock
    input wire        reset_i,           // Reset
    input wire [3:0]  avs_address_i,     // Address
    input wire        avs_read_i,        // Read
    input wire        avs_write_i,       // Write
    input wire [31:0] avs_writedata_i,   // Write data
    input wire [3:0]  avs_byteenable_i,  // Byte enables
    input wire [31:0] avs_readdata_o,    // Read data
    input wire        avs_waitrequest_o, // Wait request
    input wire        trig_cap_i,        // Trigger input
    input wire        cap2_i,            // Second capture input
    input wire        timer_out_o,       // Timer output
    input wire        match_irq_o        // Match interrupt
);
    reg [9:0] ctrl_q;
    always @(posedge clk_i or posedge reset_i)
        if (reset_i) ctrl_q <= 10'h000;
        else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0)
            ctrl_q <= avs_writedata_i[9:0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_wait_one_cycle: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("waitrequest not low after one wait");
    a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for two cycles");
    a_wait_idle: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("waitrequest low without request");
    a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > 4'h4
        |-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
    a_upper_zero: assert property (avs_read_i && !avs_waitrequest_o
        |-> avs_readdata_o[31:16] == 16'h0000) else $error("upper read bits not zero");
    a_irq_pulse: assert property (match_irq_o && $stable(trig_cap_i) && $stable(cap2_i)
        |=> !match_irq_o)
        else $error("interrupt longer than one cycle");
    a_cap_irq: assert property (ctrl_q[5] && ctrl_q[6] && ctrl_q[1:0] != 2'h0 &&
        ctrl_q[3] && $rose(cap2_i) |-> ##[1:4] match_irq_o)
        else $error("no interrupt on second capture edge");
    a_clrcmp_no_pulse: assert property (ctrl_q[1:0] == 2'h3 && ctrl_q[9]
        |=> !$rose(timer_out_o)) else $error("one-shot pulse in clear-on-match mode");
    c_irq: cover property (match_irq_o);
    c_out: cover property ($rose(timer_out_o));
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind tcc_timer tcc_timer_monitor #(.PRESCALE(PRESCALE)) i_mon (
    .clk_i             (clk_i),
    .reset_i           (reset_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .trig_cap_i        (trig_cap_i),
    .cap2_i            (cap2_i),
    .timer_out_o       (timer_out_o),
    .match_irq_o       (match_irq_o)
);

/* File: test/tcc_timer_tb.sv */
// Self-checking bench for the timer: bus, match, event, capture, one-shot.
// Assumes the design answers every bus access after one wait cycle.
`timescale 1ns/1ps
module tcc_timer_tb;
    reg         clk_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0;
    reg  [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
    reg  [31:0] avs_writedata_i = 32'h0000_0000, q;
    wire [31:0] avs_readdata_o;
    wire        avs_waitrequest_o, trig_cap_i, cap2_i, timer_out_o, match_irq_o;
    int         fail_count = 0, checks = 0, irq_n = 0, i;
    bit         hi;
    tcc_timer #(.PRESCALE(7)) i_dut (
        .clk_i             (clk_i),
        .reset_i           (reset_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .trig_cap_i        (trig_cap_i),
        .cap2_i            (cap2_i),
        .timer_out_o       (timer_out_o),
        .match_irq_o       (match_irq_o)
    );
    tcc_event_src i_src (.clk_i(clk_i), .trig_o(trig_cap_i), .cap2_o(cap2_i));
    initial forever #10 clk_i = ~clk_i;
    always @(posedge clk_i) if (match_irq_o === 1'b1) irq_n++;
    task chk(input string n, input [31:0] e, input [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task bus(input bit w, input [3:0] a, input [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a; avs_writedata_i <= d; avs_write_i <= w; avs_read_i <= !w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0; avs_read_i <= 1'b0;
    endtask
    task hw_reset;
        reset_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        irq_n = 0;
    endtask
    task watch(input int n);
        hi = 0;
        repeat (n) @(posedge clk_i) if (timer_out_o === 1'b1) hi = 1;
    endtask
    task stop_test;
        if (fail_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task t_regs;
        hw_reset; bus(0, 4'h0, 0); chk("ctrl reset", 0, q);
        bus(1, 4'h1, 32'h0000_1234); bus(0, 4'h1, 0); chk("cr0", 32'h0000_1234, q);
        bus(1, 4'h3, 32'h0000_5555); bus(0, 4'h3, 0); chk("count", 0, q);
        bus(0, 4'h7, 0); chk("unmapped", 0, q);
    endtask
    task t_match;
        hw_reset; bus(1, 4'h1, 3); bus(1, 4'h0, 1); i = 0;
        while (match_irq_o !== 1'b1 && i < 60) begin @(posedge clk_i); i++; end
        chk("match delay", 1, i >= 26 && i <= 33);
        bus(1, 4'h2, 4); i = 0;
        while (timer_out_o !== 1'b1 && i < 40) begin @(posedge clk_i); i++; end
        chk("toggle on second compare", 1, timer_out_o);
        bus(1, 4'h2, 6); i = 0;
        while (timer_out_o !== 1'b0 && i < 40) begin @(posedge clk_i); i++; end
        chk("toggle on second retake", 0, timer_out_o);
    endtask
    task t_event;
        hw_reset; bus(1, 4'h0, 32'h0000_000d);
        i_src.pulse(0, 3); i_src.pulse(0, 3); bus(0, 4'h3, 0);
        chk("count after two edges", 0, q);
        bus(0, 4'h4, 0); chk("armed edge count", 32'h0000_0008, q);
        i_src.pulse(0, 3); bus(0, 4'h3, 0);
        chk("count after three edges", 1, q);
    endtask
    task t_capture;
        hw_reset; bus(1, 4'h1, 32'h0000_ffff); bus(1, 4'h0, 32'h0000_0079);
        i_src.pulse(0, 3); i_src.pulse(1, 3); bus(0, 4'h1, 0);
        chk("cr0 kept", 32'h0000_ffff, q);
        chk("capture interrupt", 2, irq_n);
    endtask
    task t_oneshot;
        hw_reset; bus(1, 4'h2, 2); bus(1, 4'h1, 5); bus(1, 4'h0, 32'h0000_0303);
        watch(120); chk("pulse in clear mode", 0, hi);
        hw_reset; bus(1, 4'h2, 2); bus(1, 4'h1, 5); bus(1, 4'h0, 32'h0000_0301);
        watch(120); chk("pulse in free mode", 1, hi);
        chk("pulse ended", 0, timer_out_o);
    endtask
    initial begin repeat (20000) @(posedge clk_i); fail_count++; stop_test; end
    initial
    begin
        t_regs; t_match; t_event; t_capture; t_oneshot;
        stop_test;
    end
endmodule
